// >>> src/esp_pkg.sv
// package: constants, types and helpers of the expansion serial port
package esp_pkg;
  // ***************************************************************
  // clocking, line rates and timeout
  // ***************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int TMO_STEP_MS = 10;
  localparam int TMO_STEP_CYC = CLK_HZ / 1000 * TMO_STEP_MS;
  localparam logic [7:0] TMO_OFF = 8'hff;
  localparam logic [7:0] TMO_RST = 8'h32;
  localparam int NPORT = 2;
  localparam logic [4:0] NODES_485 = 5'h1f;
  localparam logic [4:0] NODES_232 = 5'h01;
  localparam logic [2:0] RATE_RST = 3'h7;
  localparam logic [15:0] DIV_TAB [8] = '{
    16'(CLK_HZ / 1200), 16'(CLK_HZ / 2400), 16'(CLK_HZ / 4800),
    16'(CLK_HZ / 9600), 16'(CLK_HZ / 19200), 16'(CLK_HZ / 38400),
    16'(CLK_HZ / 57600), 16'(CLK_HZ / 115200)};
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [2:0] BCC_XOR = 3'h0;
  localparam logic [2:0] BCC_ADD = 3'h1;
  localparam logic [2:0] BCC_ADD2C = 3'h2;
  localparam logic [2:0] BCC_LRC = 3'h3;
  localparam logic [2:0] BCC_CRC = 3'h4;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [6:0] PORT_STRIDE = 7'h20;
  localparam logic [6:0] REG_CFG = 7'h00;
  localparam logic [6:0] REG_CTRL = 7'h04;
  localparam logic [6:0] REG_TX = 7'h08;
  localparam logic [6:0] REG_RX = 7'h0c;
  localparam logic [6:0] REG_STAT = 7'h10;
  localparam logic [6:0] REG_SLAVE = 7'h14;
  localparam logic [6:0] REG_BCC_CTRL = 7'h40;
  localparam logic [6:0] REG_BCC_DATA = 7'h44;
  localparam logic [6:0] REG_BCC_RES = 7'h48;
  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic [7:0] tmo;
    logic [4:0] slave_const;
    logic slave_src;
    logic rs485;
    logic user_mode;
    logic stop2;
    logic [1:0] par;
    logic data8;
    logic [2:0] rate;
  } esp_cfg_t;
  localparam int CFG_W = $bits(esp_cfg_t);
  localparam esp_cfg_t CFG_RST = '{tmo: TMO_RST, slave_const: 5'h00,
    slave_src: 1'b0, rs485: 1'b0, user_mode: 1'b0, stop2: 1'b0,
    par: PAR_EVEN, data8: 1'b0, rate: RATE_RST};
  typedef struct packed {
    logic [10:0] zero_hi;
    logic [4:0] node_lim;
    logic [2:0] zero_mid;
    logic [4:0] slave;
    logic rx_active;
    logic tx_busy;
    logic cfg_rej;
    logic ovr;
    logic ferr;
    logic perr;
    logic tmo_err;
    logic rx_valid;
  } esp_stat_t;
  typedef struct packed {
    logic [29:0] zero;
    logic rx_stop;
    logic rx_start;
  } esp_ctrl_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [6:0] address;
    logic [31:0] writedata;
  } esp_avs_req_t;
  typedef struct packed {
    logic done;
    logic [7:0] data;
    logic perr;
    logic ferr;
  } esp_rx_t;
  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [15:0] esp_baud_div(input logic [2:0] r);
    return DIV_TAB[r];
  endfunction : esp_baud_div
  function automatic logic esp_par_bit(input logic [1:0] par,
                                       input logic [7:0] d);
    return (par == PAR_ODD) ? ~^d : ^d;
  endfunction : esp_par_bit
  function automatic logic esp_sel(input logic [6:0] a, input int p,
                                   input logic [6:0] off);
    return a == 7'(p * 32 + int'(off));
  endfunction : esp_sel
endpackage : esp_pkg

// >>> src/esp_serial.sv
// one asynchronous serial channel: character transmitter and receiver
`timescale 1ns/10ps
module esp_serial (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire esp_pkg::esp_cfg_t i_cfg,
  input wire logic i_tx_go,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_tx_busy,
  output esp_pkg::esp_rx_t o_rx
);
  import esp_pkg::*;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} esp_rxst_t;
  typedef enum logic {TX_IDLE, TX_SEND} esp_txst_t;
  // ***************************************************************
  // frame shape
  // ***************************************************************
  logic [15:0] div;
  logic has_par;
  logic [3:0] n_data;
  logic [3:0] n_tx;
  logic [3:0] n_rx;
  logic [7:0] tx_data;
  logic [10:0] tx_load;
  assign div = esp_baud_div(i_cfg.rate);
  assign has_par = i_cfg.par != PAR_NONE;
  assign n_data = i_cfg.data8 ? 4'h8 : 4'h7;
  assign n_tx = 4'(4'h2 + n_data + {3'h0, has_par} + {3'h0, i_cfg.stop2});
  assign n_rx = 4'(n_data + {3'h0, has_par} + 4'h1);
  assign tx_data = i_cfg.data8 ? i_tx_byte : {1'b0, i_tx_byte[6:0]};
  // stop bits fill the unused top of the shifter
  always_comb
  begin
    tx_load = '1;
    tx_load[6:0] = tx_data[6:0];
    if (i_cfg.data8)
    begin
      tx_load[7] = tx_data[7];
    end
    if (has_par)
    begin
      tx_load[n_data] = esp_par_bit(i_cfg.par, tx_data);
    end
  end
  // ***************************************************************
  // transmitter
  // ***************************************************************
  esp_txst_t tx_st;
  logic [10:0] tx_sh;
  logic [3:0] tx_left;
  logic [15:0] tx_cnt;
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      tx_st <= TX_IDLE;
      o_txd <= 1'b1;
      o_tx_busy <= 1'b0;
      tx_sh <= '1;
      tx_left <= 4'h0;
      tx_cnt <= 16'h0;
    end
    else
    begin
      unique case (tx_st)
        TX_IDLE:
          if (i_tx_go)
          begin
            o_txd <= 1'b0;
            tx_sh <= tx_load;
            tx_left <= 4'(n_tx - 4'h1);
            tx_cnt <= 16'(div - 16'h1);
            o_tx_busy <= 1'b1;
            tx_st <= TX_SEND;
          end
        TX_SEND:
          if (tx_cnt != 16'h0)
          begin
            tx_cnt <= 16'(tx_cnt - 16'h1);
          end
          else if (tx_left == 4'h0)
          begin
            o_tx_busy <= 1'b0;
            tx_st <= TX_IDLE;
          end
          else
          begin
            o_txd <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_left <= 4'(tx_left - 4'h1);
            tx_cnt <= 16'(div - 16'h1);
          end
      endcase
    end
  end
  // ***************************************************************
  // receiver
  // ***************************************************************
  esp_rxst_t rx_st;
  logic rxd_q;
  logic [15:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [10:0] rx_sh;
  logic [10:0] rx_bits;
  logic [7:0] rx_data;
  logic rx_last;
  logic rx_perr;
  logic rx_ferr;
  always_comb
  begin
    rx_bits = rx_sh;
    rx_bits[rx_idx] = i_rxd;
  end
  assign rx_last = rx_idx == 4'(n_rx - 4'h1);
  assign rx_data = i_cfg.data8 ? rx_bits[7:0] : {1'b0, rx_bits[6:0]};
  assign rx_perr = has_par &&
    (rx_bits[n_data] != esp_par_bit(i_cfg.par, rx_data));
  // only the first stop bit is checked, so a short second one is taken
  assign rx_ferr = !rx_bits[4'(n_data + {3'h0, has_par})];
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      rx_st <= RX_IDLE;
      rxd_q <= 1'b1;
      rx_cnt <= 16'h0;
      rx_idx <= 4'h0;
      rx_sh <= '1;
      o_rx <= '0;
    end
    else
    begin
      rxd_q <= i_rxd;
      o_rx.done <= 1'b0;
      unique case (rx_st)
        RX_IDLE:
          if (rxd_q && !i_rxd)
          begin
            rx_cnt <= {1'b0, div[15:1]};
            rx_st <= RX_START;
          end
        RX_START:
          if (rx_cnt != 16'h0)
          begin
            rx_cnt <= 16'(rx_cnt - 16'h1);
          end
          else if (!i_rxd)
          begin
            rx_cnt <= 16'(div - 16'h1);
            rx_idx <= 4'h0;
            rx_sh <= '1;
            rx_st <= RX_BITS;
          end
          else
          begin
            rx_st <= RX_IDLE;
          end
        RX_BITS:
          if (rx_cnt != 16'h0)
          begin
            rx_cnt <= 16'(rx_cnt - 16'h1);
          end
          else
          begin
            rx_sh <= rx_bits;
            rx_cnt <= 16'(div - 16'h1);
            rx_idx <= 4'(rx_idx + 4'h1);
            if (rx_last)
            begin
              o_rx <= '{done: 1'b1, data: rx_data, perr: rx_perr,
                        ferr: rx_ferr};
              rx_st <= RX_IDLE;
            end
          end
      endcase
    end
  end
endmodule : esp_serial

// >>> src/esp_serial_port.sv
// expansion serial port: two channels, register slave, block check
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module esp_serial_port #(
  parameter int TMO_STEP_CYC = esp_pkg::TMO_STEP_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire esp_pkg::esp_avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [esp_pkg::NPORT-1:0] i_rxd,
  output logic [esp_pkg::NPORT-1:0] o_txd,
  output logic [esp_pkg::NPORT-1:0] o_drv_en
);
  import esp_pkg::*;
  // ***************************************************************
  // bus handshake
  // ***************************************************************
  logic wr_ok;
  logic rd_take;
  logic rd_load;
  logic [31:0] port_rd [NPORT];
  logic [31:0] bcc_rd;
  logic [31:0] next_rdata;
  assign wr_ok = i_avs.write && !o_avs_waitrequest;
  assign rd_take = i_avs.read && !o_avs_waitrequest;
  assign rd_load = i_avs.read && o_avs_waitrequest;
  assign next_rdata = i_avs.address[6] ? bcc_rd :
                      port_rd[i_avs.address[5]];
  // one wait cycle per access keeps read data a plain register
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      o_avs_waitrequest <= !((i_avs.read || i_avs.write) &&
                             o_avs_waitrequest);
      if (rd_load)
      begin
        o_avs_readdata <= next_rdata;
      end
    end
  end
  // ***************************************************************
  // serial ports
  // ***************************************************************
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    esp_cfg_t cfg;
    esp_cfg_t cfg_new;
    esp_stat_t stat;
    esp_stat_t stat_clr;
    esp_ctrl_t ctrl_wr;
    esp_rx_t rx;
    logic sel_cfg;
    logic sel_ctrl;
    logic sel_tx;
    logic sel_rx;
    logic sel_stat;
    logic sel_slave;
    logic cfg_bad;
    logic tx_busy;
    logic tx_go;
    logic [7:0] tx_byte;
    logic capture;
    logic rd_rx;
    logic rx_start;
    logic rx_stop;
    logic tmo_run;
    logic tmo_tick;
    logic tmo_hit;
    logic [4:0] slave_reg;
    logic [4:0] slave_eff;
    logic [4:0] node_lim;
    logic rx_active;
    logic rx_valid;
    logic tmo_err;
    logic perr;
    logic ferr;
    logic ovr;
    logic cfg_rej;
    logic drv_en;
    logic [7:0] rx_data;
    logic [7:0] tmo_steps;
    logic [31:0] tmo_cyc;
    assign sel_cfg = esp_sel(i_avs.address, p, REG_CFG);
    assign sel_ctrl = esp_sel(i_avs.address, p, REG_CTRL);
    assign sel_tx = esp_sel(i_avs.address, p, REG_TX);
    assign sel_rx = esp_sel(i_avs.address, p, REG_RX);
    assign sel_stat = esp_sel(i_avs.address, p, REG_STAT);
    assign sel_slave = esp_sel(i_avs.address, p, REG_SLAVE);
    assign cfg_new = esp_cfg_t'(i_avs.writedata[CFG_W-1:0]);
    assign ctrl_wr = esp_ctrl_t'(i_avs.writedata);
    assign stat_clr = esp_stat_t'(i_avs.writedata);
    // whole word is dropped, so no half-applied setting reaches a line
    assign cfg_bad = (!cfg_new.data8 && cfg_new.par == PAR_NONE) ||
                     cfg_new.par == 2'h3 ||
                     cfg_new.tmo == 8'h00;
    assign slave_eff = cfg.slave_src ? slave_reg :
                       cfg.slave_const;
    assign node_lim = cfg.rs485 ? NODES_485 : NODES_232;
    assign capture = rx.done &&
                     (!cfg.user_mode || rx_active);
    assign rd_rx = rd_take && sel_rx;
    assign rx_start = wr_ok && sel_ctrl && ctrl_wr.rx_start;
    assign rx_stop = wr_ok && sel_ctrl && ctrl_wr.rx_stop;
    assign tmo_run = cfg.user_mode && rx_active &&
                     cfg.tmo != TMO_OFF;
    assign tmo_tick = tmo_run &&
                      tmo_cyc == 32'(TMO_STEP_CYC - 1);
    assign tmo_hit = tmo_tick &&
                     8'(tmo_steps + 8'h1) == cfg.tmo;
    assign stat = '{zero_hi: 11'h0, node_lim: node_lim,
                    zero_mid: 3'h0, slave: slave_eff,
                    rx_active: rx_active, tx_busy: tx_busy,
                    cfg_rej: cfg_rej, ovr: ovr, ferr: ferr,
                    perr: perr, tmo_err: tmo_err, rx_valid: rx_valid};
    assign port_rd[p] = sel_cfg ? 32'(cfg) :
                        sel_stat ? 32'(stat) :
                        sel_rx ? {24'h0, rx_data} :
                        sel_slave ? {27'h0, slave_reg} :
                        sel_tx ? {31'h0, tx_busy} : 32'h0;
    assign o_drv_en[p] = drv_en;
    esp_serial u_serial (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_cfg(cfg),
      .i_tx_go(tx_go),
      .i_tx_byte(tx_byte),
      .i_rxd(i_rxd[p]),
      .o_txd(o_txd[p]),
      .o_tx_busy(tx_busy),
      .o_rx(rx)
    );
    always_ff @(posedge i_clock)
    begin
      if (!i_nrst)
      begin
        cfg <= CFG_RST;
        slave_reg <= 5'h00;
      end
      else
      begin
        if (wr_ok && sel_cfg && !cfg_bad)
        begin
          cfg <= cfg_new;
        end
        if (wr_ok && sel_slave)
        begin
          slave_reg <= i_avs.writedata[4:0];
        end
      end
    end
    // receive state; a captured character beats a clear in the same cycle, and a stop or timeout beats a start
    always_ff @(posedge i_clock)
    begin
      if (!i_nrst)
      begin
        rx_active <= 1'b0;
        rx_valid <= 1'b0;
        rx_data <= 8'h00;
        ovr <= 1'b0;
      end
      else
      begin
        if (tmo_hit || rx_stop)
        begin
          rx_active <= 1'b0;
        end
        else if (rx_start)
        begin
          rx_active <= 1'b1;
        end
        if (capture)
        begin
          rx_data <= rx.data;
        end
        rx_valid <= capture || (rx_valid && !rd_rx);
        ovr <= (capture && rx_valid && !rd_rx) ||
               (ovr && !(wr_ok && sel_stat && stat_clr.ovr));
      end
    end
    always_ff @(posedge i_clock)
    begin
      if (!i_nrst)
      begin
        tmo_err <= 1'b0;
        perr <= 1'b0;
        ferr <= 1'b0;
        cfg_rej <= 1'b0;
      end
      else
      begin
        tmo_err <= tmo_hit ||
          (tmo_err && !(wr_ok && sel_stat && stat_clr.tmo_err));
        perr <= (capture && rx.perr) ||
          (perr && !(wr_ok && sel_stat && stat_clr.perr));
        ferr <= (capture && rx.ferr) ||
          (ferr && !(wr_ok && sel_stat && stat_clr.ferr));
        cfg_rej <= (wr_ok && sel_cfg && cfg_bad) ||
          (cfg_rej && !(wr_ok && sel_stat && stat_clr.cfg_rej));
      end
    end
    // idle time restarts on every character taken in
    always_ff @(posedge i_clock)
    begin
      if (!i_nrst || !tmo_run || capture || rx_start)
      begin
        tmo_cyc <= 32'h0;
        tmo_steps <= 8'h00;
      end
      else if (tmo_tick)
      begin
        tmo_cyc <= 32'h0;
        tmo_steps <= 8'(tmo_steps + 8'h1);
      end
      else
      begin
        tmo_cyc <= 32'(tmo_cyc + 32'h1);
      end
    end
    // a byte written while busy is dropped; software polls tx_busy
    always_ff @(posedge i_clock)
    begin
      if (!i_nrst)
      begin
        tx_go <= 1'b0;
        tx_byte <= 8'h00;
        drv_en <= 1'b0;
      end
      else
      begin
        tx_go <= wr_ok && sel_tx && !tx_busy && !tx_go;
        if (wr_ok && sel_tx)
        begin
          tx_byte <= i_avs.writedata[7:0];
        end
        drv_en <= !cfg.rs485 || tx_busy || tx_go;
      end
    end
  end
  // ***************************************************************
  // block check generator
  // ***************************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
  logic [2:0] bcc_type;
  logic [15:0] bcc_acc;
  logic [15:0] next_acc;
  logic [7:0] bcc_in;
  logic [7:0] bcc_neg;
  logic sel_bctl;
  logic sel_bdat;
  logic sel_bres;
  assign sel_bctl = esp_sel(i_avs.address, 0, REG_BCC_CTRL);
  assign sel_bdat = esp_sel(i_avs.address, 0, REG_BCC_DATA);
  assign sel_bres = esp_sel(i_avs.address, 0, REG_BCC_RES);
  assign bcc_in = i_avs.writedata[7:0];
  assign next_acc = (bcc_type == BCC_CRC) ? crc_byte(bcc_acc, bcc_in) :
                    (bcc_type == BCC_XOR) ?
                      {8'h00, bcc_acc[7:0] ^ bcc_in} :
                      {8'h00, 8'(bcc_acc[7:0] + bcc_in)};
  assign bcc_neg = 8'(~bcc_acc[7:0] + 8'h01);
  assign bcc_rd = sel_bctl ? {29'h0, bcc_type} :
                  !sel_bres ? 32'h0 :
                  (bcc_type == BCC_ADD2C || bcc_type == BCC_LRC) ?
                    {24'h0, bcc_neg} : {16'h0, bcc_acc};
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      bcc_type <= BCC_XOR;
      bcc_acc <= 16'h0000;
    end
    else if (wr_ok && sel_bctl)
    begin
      bcc_type <= i_avs.writedata[2:0];
      bcc_acc <= (i_avs.writedata[2:0] == BCC_CRC) ? CRC_INIT : 16'h0000;
    end
    else if (wr_ok && sel_bdat)
    begin
      bcc_acc <= next_acc;
    end
  end
endmodule : esp_serial_port

// >>> sim/esp_serial_port_properties.sv
// port checker of the expansion serial port, with its bind
`timescale 1ns/10ps
module esp_port_chk #(
  parameter int TMO_STEP_CYC = esp_pkg::TMO_STEP_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire esp_pkg::esp_avs_req_t i_avs,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [esp_pkg::NPORT-1:0] i_rxd,
  input wire logic [esp_pkg::NPORT-1:0] o_txd,
  input wire logic [esp_pkg::NPORT-1:0] o_drv_en
);
  import esp_pkg::*;
  // fastest rate gives the shortest legal level run
  localparam int MIN_RUN = CLK_HZ / 115200;
  wire req = i_avs.read | i_avs.write;
  logic txd_q;
  int run;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_clock)
  begin
    txd_q <= o_txd[0];
    if (!i_nrst)
      run <= 1000;
    else if (o_txd[0] != txd_q)
      run <= 1;
    else if (run < 1000)
      run <= run + 1;
  end
  sequence acc_s;
    req && !o_avs_waitrequest;
  endsequence
  sequence rd_s(logic [6:0] a);
    acc_s ##0 (i_avs.read && i_avs.address == a);
  endsequence
  wait_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_answer_a: assert property (req && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("no answer one cycle after request");
  wait_cause_a: assert property (!o_avs_waitrequest |-> req)
    else $error("answer without a request");
  rdata_hold_a: assert property ($changed(o_avs_readdata) |->
    $past(i_avs.read)) else $error("read data changed without a read");
  unmap_zero_a: assert property (rd_s(7'h7c) |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  node_lim_a: assert property (rd_s(REG_STAT) |->
    o_avs_readdata[20:16] inside {NODES_232, NODES_485})
    else $error("node limit field wrong");
  drv_tx_a: assert property (o_txd != 2'h3 |->
    (o_drv_en | o_txd) == 2'h3) else $error("line low with driver off");
  bit_time_a: assert property (o_txd[0] != txd_q |->
    run >= MIN_RUN) else $error("line level shorter than a bit time");
  tx_idle_a: assert property ($rose(i_nrst) |-> o_txd == 2'h3)
    else $error("line not idle high after reset");
endmodule : esp_port_chk
bind esp_serial_port esp_port_chk #(.TMO_STEP_CYC(TMO_STEP_CYC))
  esp_port_chk_i (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_avs(i_avs),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_drv_en(o_drv_en));

// >>> sim/esp_line_dev.sv
// serial device on the far side of one port
`timescale 1ns/10ps
module esp_line_dev (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_line
);
  int div = esp_pkg::CLK_HZ / 115200;
  int nb = 7;
  logic [1:0] par = 2'h2;
  logic st2 = 1'b0;
  logic [7:0] rx_byte;
  logic rx_bad;
  int cnt = 0;
  initial o_line = 1'b1;
  function automatic logic pbit(input logic [7:0] d);
    return (par == 2'h1) ? ~^d : ^d;
  endfunction : pbit
  task automatic line_bit(input logic b);
    @(posedge i_clock);
    o_line <= b;
    repeat (div - 1) @(posedge i_clock);
  endtask : line_bit
  task automatic send(input logic [7:0] d);
    logic [7:0] m;
    m = (nb == 7) ? (d & 8'h7f) : d;
    line_bit(1'b0);
    for (int k = 0; k < nb; k++) line_bit(m[k]);
    if (par != 2'h0) line_bit(pbit(m));
    line_bit(1'b1);
    if (st2) line_bit(1'b1);
  endtask : send
  // mid-bit sampling, so a late edge of a few cycles is tolerated
  initial forever
  begin
    @(negedge i_line);
    repeat (div / 2) @(posedge i_clock);
    rx_bad = i_line;
    rx_byte = 8'h00;
    for (int n = 0; n < nb; n++)
    begin
      repeat (div) @(posedge i_clock);
      rx_byte[n] = i_line;
    end
    if (par != 2'h0)
    begin
      repeat (div) @(posedge i_clock);
      rx_bad = rx_bad | (i_line != pbit(rx_byte));
    end
    repeat (div) @(posedge i_clock);
    rx_bad = rx_bad | !i_line;
    cnt++;
  end
endmodule : esp_line_dev

// >>> sim/test_esp_serial_port.sv
// testbench of the expansion serial port
`timescale 1ns/10ps
module test_esp_serial_port;
  import esp_pkg::*;
  localparam int STEP = 20;
  localparam logic [31:0] R = 32'(CFG_RST);
  localparam logic [31:0] P1 = {9'h0, 8'hff, 5'h0, 3'h1, 1'b1, PAR_ODD,
    1'b1, 3'h6};
  localparam logic [31:0] P1T = {P1[31:23], 8'h03, P1[14:0]};
  localparam logic [6:0] S = PORT_STRIDE;
  logic i_clock;
  logic i_nrst;
  esp_avs_req_t avs;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] rxd;
  logic [1:0] txd;
  logic [1:0] drv;
  logic [31:0] q;
  logic [31:0] bx [5];
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  esp_serial_port #(.TMO_STEP_CYC(STEP)) esp_serial_port_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_rxd(rxd), .o_txd(txd), .o_drv_en(drv));
  esp_line_dev dev0 (.i_clock(i_clock), .i_line(txd[0]), .o_line(rxd[0]));
  esp_line_dev dev1 (.i_clock(i_clock), .i_line(txd[1]), .o_line(rxd[1]));
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction : crc
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // whole run needs about 21k cycles
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors++;
      test_done();
    end
  end
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  task acc(input logic r, input logic [6:0] a, input logic [31:0] d);
    @(posedge i_clock);
    avs <= '{read: r, write: !r, address: a, writedata: d};
    do @(posedge i_clock); while (wreq !== 1'b0);
    q = rdata;
    avs <= '0;
  endtask : acc
  task rd(input logic [6:0] a, input logic [31:0] m, input logic [31:0] e,
          input string nm);
    acc(1'b1, a, 32'h0);
    check(nm, q & m, e);
  endtask : rd
  initial
  begin
    i_nrst = 1'b0;
    avs = '0;
    bx = '{32'h26, 32'h46, 32'hba, 32'hba,
      32'(crc(crc(16'hffff, 8'h12), 8'h34))};
    repeat (10) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd(REG_CFG, '1, R, "cfg reset");
    rd(REG_STAT, '1, 32'h00010000, "stat reset");
    rd(7'h7c, '1, 32'h0, "unmapped");
    rd(REG_CTRL, '1, 32'h0, "ctrl");
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, REG_CFG, {R[31:3], 3'(i)});
      rd(REG_CFG, 32'h7, 32'(i), "rate");
    end
    acc(1'b0, REG_CFG, R & ~32'h30);
    rd(REG_CFG, '1, R, "7 bits none");
    rd(REG_STAT, 32'h20, 32'h20, "reject flag");
    acc(1'b0, REG_STAT, 32'h20);
    acc(1'b0, REG_CFG, R & ~32'h30 | 32'h8);
    rd(REG_CFG, '1, R & ~32'h30 | 32'h8, "8 bits none");
    acc(1'b0, REG_CFG, R | 32'h7c00);
    rd(REG_STAT, 32'h1f1f20, 32'h011f00, "fixed slave");
    acc(1'b0, REG_SLAVE, 32'h15);
    acc(1'b0, REG_CFG, R | 32'h300);
    rd(REG_STAT, 32'h1f1f00, 32'h1f1500, "reg slave");
    // port 1 in user mode at 57600, 8 odd 2; both ports busy at once
    acc(1'b0, S + REG_CFG, P1);
    dev1.div = CLK_HZ / 57600;
    dev1.nb = 8;
    dev1.par = PAR_ODD;
    dev1.st2 = 1'b1;
    acc(1'b0, S + REG_CTRL, 32'h1);
    acc(1'b0, REG_TX, 32'hd3);
    fork
      dev1.send(8'ha5);
      wait (dev0.cnt == 1);
    join
    check("tx byte", 32'(dev0.rx_byte), 32'h53);
    check("tx frame", 32'(dev0.rx_bad), 32'h0);
    rd(S + REG_RX, 32'hff, 32'ha5, "rx byte");
    rd(S + REG_STAT, 32'h1d, 32'h0, "rx stat");
    acc(1'b0, S + REG_CTRL, 32'h2);
    dev1.send(8'h3c);
    rd(S + REG_STAT, 32'h1, 32'h0, "user idle");
    dev0.send(8'h41);
    rd(REG_RX, 32'hff, 32'h41, "maint rx");
    check("drv idle", 32'(drv), 32'h2);
    acc(1'b0, S + REG_CFG, P1T);
    acc(1'b0, S + REG_CTRL, 32'h1);
    rd(S + REG_STAT, 32'h82, 32'h80, "tmo early");
    repeat (3 * STEP + 10) @(posedge i_clock);
    rd(S + REG_STAT, 32'h82, 32'h02, "tmo hit");
    acc(1'b0, S + REG_STAT, 32'h2);
    repeat (3 * STEP + 10) @(posedge i_clock);
    rd(S + REG_STAT, 32'h82, 32'h0, "tmo idle");
    acc(1'b0, S + REG_CFG, P1);
    acc(1'b0, S + REG_CTRL, 32'h1);
    repeat (3 * STEP + 10) @(posedge i_clock);
    rd(S + REG_STAT, 32'h82, 32'h80, "tmo off");
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b0, REG_BCC_CTRL, 32'(i));
      acc(1'b0, REG_BCC_DATA, 32'h12);
      acc(1'b0, REG_BCC_DATA, 32'h34);
      rd(REG_BCC_RES, 32'hffff, bx[i], "bcc");
    end
    test_done();
  end
endmodule : test_esp_serial_port
